// ### hw/sgt_timer.v
// Summary of operation
// RL1: sixteen-bit up-counter read and written as separate high and low bytes.
// RL2: writing either count byte replaces that byte of the running count at once.
// RL3: off when on bit clear; always counts unless gate qualifying is set.
// RL4: source select picks instruction clock, system clock, external pin, or sensing oscillator.
// RL5: system clock source advances four counts per instruction cycle, before prescaling.
// RL6: external source increments the counter on each of its rising edges.
// RL7: external clock always passes the synchroniser, through three stages or, with sync bypass, two.
// RL8: counter mode needs a falling edge first after enable, byte write, re-enable.
// RL9: prescale select divides the chosen clock by 1, 2, 4 or 8.
// RL10: prescaler is hidden from software and cleared by any count byte write.
// RL11: oscillator enable starts the crystal oscillator; it keeps running in sleep.
// RL12: software should let the oscillator settle, e.g. preset FC00h and await overflow.
// RL13: rolling from FFFFh to 0000h sets the overflow flag; software clears it.
// RL14: with gate qualifying on and gate inactive, counter holds its value.
// RL15: sync bypass takes the external clock one synchroniser stage earlier.
// RL16: with source pin, oscillator enable picks crystal oscillator instead of pin.
// RL17: external count-enable level applies only while gate qualifying is set.
`include "sgt_consts.vh"

module sgt_timer (
    input wire core_clk_i,
    input wire rst_i,
    input wire [3:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output reg [31:0] avs_readdata_o,
    output reg avs_waitrequest_o,
    input wire external_clock_pin_i,
    input wire cap_sense_osc_i,
    input wire crystal_osc_clk_i,
    input wire gate_count_enable_i,
    output reg crystal_osc_run_o,
    output reg irq_o
);
    reg [7:0] timer_control_reg;
    reg [7:0] gate_control_reg;
    reg [7:0] count_low_byte_reg;
    reg [7:0] count_high_byte_reg;
    reg [0:0] status_reg;
    reg [0:0] mask_reg;
    reg pend_reg;
    reg [`SGT_INSTR_DIV_W-1:0] instr_div_reg;
    reg [2:0] pin_sync_reg;
    reg [2:0] cap_sync_reg;
    reg [2:0] osc_sync_reg;
    reg [1:0] gate_sync_reg;
    reg ext_prev_reg;
    reg armed_reg;
    reg on_prev_reg;

    wire timer_on_bit;
    wire gate_qualify_bit;
    wire gate_polarity_bit;
    wire sync_bypass_bit;
    wire crystal_osc_enable;
    wire [1:0] clock_source_select;
    wire [1:0] prescale_select;
    wire bus_wr;
    wire bus_rd;
    wire wr_lo;
    wire wr_hi;
    wire wr_cnt;
    wire ext_sel;
    reg ext_level;
    wire ext_rise;
    wire ext_fall;
    reg src_tick;
    reg [31:0] read_word;
    wire ctrl_wr;
    wire gate_wr;
    wire mask_wr;
    wire stat_wr;
    wire count_step;
    wire ps_tick;
    wire run_en;
    wire [15:0] count_now;
    wire [15:0] count_inc;
    wire roll;

    // bus write to a given word with its low byte lane enabled
    function hit;
        input [3:0] addr;
        input [3:0] want;
        input [3:0] be;
        begin
            hit = (addr == want) && be[0];
        end
    endfunction

    assign timer_on_bit = timer_control_reg[`SGT_CTRL_ON];
    assign sync_bypass_bit = timer_control_reg[`SGT_CTRL_SYNC_BYP];
    assign crystal_osc_enable = timer_control_reg[`SGT_CTRL_OSC_EN];
    assign prescale_select = timer_control_reg[`SGT_CTRL_PS_HI:`SGT_CTRL_PS_LO];
    assign clock_source_select = timer_control_reg[`SGT_CTRL_CS_HI:`SGT_CTRL_CS_LO];
    assign gate_qualify_bit = gate_control_reg[`SGT_GATE_QUAL];
    assign gate_polarity_bit = gate_control_reg[`SGT_GATE_POL];

    // a request is taken on the edge where waitrequest is low
    assign bus_wr = avs_write_i && !avs_waitrequest_o;
    assign bus_rd = avs_read_i && !avs_waitrequest_o;
    assign wr_lo = bus_wr && hit(avs_address_i, `SGT_ADDR_CNT_LO, avs_byteenable_i);
    assign wr_hi = bus_wr && hit(avs_address_i, `SGT_ADDR_CNT_HI, avs_byteenable_i);
    assign wr_cnt = wr_lo || wr_hi;
    assign ctrl_wr = bus_wr && hit(avs_address_i, `SGT_ADDR_CTRL, avs_byteenable_i);
    assign gate_wr = bus_wr && hit(avs_address_i, `SGT_ADDR_GATE, avs_byteenable_i);
    assign mask_wr = bus_wr && hit(avs_address_i, `SGT_ADDR_MASK, avs_byteenable_i);
    assign stat_wr = bus_wr && hit(avs_address_i, `SGT_ADDR_STAT, avs_byteenable_i);

    // RL4 RL16 external source choice
    assign ext_sel = clock_source_select[1];
    // RL7 RL15 bypass taps one stage earlier
    always @* begin
        ext_level = 1'b0;
        case (clock_source_select)
            `SGT_CS_CAP: begin
                ext_level = sync_bypass_bit ? cap_sync_reg[1] : cap_sync_reg[2];
            end
            `SGT_CS_PIN: begin
                if (crystal_osc_enable) begin
                    ext_level = sync_bypass_bit ? osc_sync_reg[1] : osc_sync_reg[2];
                end else begin
                    ext_level = sync_bypass_bit ? pin_sync_reg[1] : pin_sync_reg[2];
                end
            end
            default: begin
                // internal sources keep the edge detector quiet
                ext_level = 1'b0;
            end
        endcase
    end
    // RL6 rising edge detect
    assign ext_rise = ext_level && !ext_prev_reg;
    assign ext_fall = !ext_level && ext_prev_reg;

    // RL4 RL5 tick per source before prescaling
    always @* begin
        src_tick = 1'b0;
        case (clock_source_select)
            `SGT_CS_INSTR: begin
                src_tick = (instr_div_reg == 2'h0);
            end
            `SGT_CS_SYS: begin
                src_tick = 1'b1;
            end
            default: begin
                src_tick = ext_rise && armed_reg;
            end
        endcase
    end

    // RL3 RL14 RL17 enable table with gate polarity
    assign run_en = timer_on_bit &&
                    (!gate_qualify_bit || (gate_sync_reg[1] == gate_polarity_bit));

    // RL1 sixteen-bit count view
    assign count_now = {count_high_byte_reg, count_low_byte_reg};
    assign count_inc = count_now + 16'h0001;
    // RL13 rollover detect
    assign count_step = ps_tick && run_en;
    assign roll = count_step && (count_now == 16'hFFFF);

    // RL9 RL10 prescaler cleared on byte writes
    sgt_prescale u_prescale (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .clear_i(wr_cnt),
        .tick_i(src_tick && run_en),
        .sel_i(prescale_select),
        .tick_o(ps_tick)
    );

    // pin inputs: sync chains
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            pin_sync_reg <= 3'h0;
            cap_sync_reg <= 3'h0;
            osc_sync_reg <= 3'h0;
            gate_sync_reg <= 2'h0;
        end else begin
            pin_sync_reg <= {pin_sync_reg[1:0], external_clock_pin_i};
            cap_sync_reg <= {cap_sync_reg[1:0], cap_sense_osc_i};
            osc_sync_reg <= {osc_sync_reg[1:0], crystal_osc_clk_i};
            gate_sync_reg <= {gate_sync_reg[0], gate_count_enable_i};
        end
    end

    // instruction clock phase, free running
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            instr_div_reg <= 2'h0;
        end else begin
            instr_div_reg <= instr_div_reg + 2'h1;
        end
    end

    // RL8 arm only after a falling edge once disarmed
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            ext_prev_reg <= 1'b0;
            armed_reg <= 1'b0;
            on_prev_reg <= 1'b0;
        end else begin
            ext_prev_reg <= ext_level;
            on_prev_reg <= timer_on_bit;
            if (wr_cnt || !timer_on_bit || !ext_sel) begin
                armed_reg <= 1'b0;
            end else if (ext_fall) begin
                armed_reg <= 1'b1;
            end
        end
    end

    // control register
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            timer_control_reg <= `SGT_CTRL_RST;
        end else if (ctrl_wr) begin
            timer_control_reg <= avs_writedata_i[7:0];
        end
    end

    // gate register
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            gate_control_reg <= `SGT_GATE_RST;
        end else if (gate_wr) begin
            gate_control_reg <= avs_writedata_i[7:0];
        end
    end

    // interrupt mask
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            mask_reg <= 1'b0;
        end else if (mask_wr) begin
            mask_reg <= avs_writedata_i[0];
        end
    end

    // RL2 low byte write wins
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            count_low_byte_reg <= 8'h00;
        end else if (wr_lo) begin
            count_low_byte_reg <= avs_writedata_i[7:0];
        end else if (count_step) begin
            count_low_byte_reg <= count_inc[7:0];
        end
    end

    // RL2 high byte write wins
    // a low byte write in the same cycle drops the carry, so the pair never mixes old and new
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            count_high_byte_reg <= 8'h00;
        end else if (wr_hi) begin
            count_high_byte_reg <= avs_writedata_i[7:0];
        end else if (count_step && !wr_lo) begin
            count_high_byte_reg <= count_inc[15:8];
        end
    end

    // RL13 sticky overflow flag, set wins over write-one-clear
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            status_reg <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            if (roll && !wr_cnt) begin
                status_reg[`SGT_STAT_OVF] <= 1'b1;
            end else if (stat_wr && avs_writedata_i[`SGT_STAT_OVF]) begin
                status_reg[`SGT_STAT_OVF] <= 1'b0;
            end
            irq_o <= |(status_reg & mask_reg);
        end
    end

    // RL11 oscillator run follows enable, independent of timer on
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            crystal_osc_run_o <= 1'b0;
        end else begin
            crystal_osc_run_o <= crystal_osc_enable;
        end
    end

    // read word for the addressed register; unmapped words read zero
    always @* begin
        read_word = 32'h00000000;
        case (avs_address_i)
            `SGT_ADDR_CTRL: begin
                read_word = {24'h000000, timer_control_reg};
            end
            `SGT_ADDR_GATE: begin
                read_word = {24'h000000, gate_control_reg};
            end
            `SGT_ADDR_CNT_LO: begin
                read_word = {24'h000000, count_low_byte_reg};
            end
            `SGT_ADDR_CNT_HI: begin
                read_word = {24'h000000, count_high_byte_reg};
            end
            `SGT_ADDR_STAT: begin
                read_word = {31'h00000000, status_reg};
            end
            `SGT_ADDR_MASK: begin
                read_word = {31'h00000000, mask_reg};
            end
            default: begin
                read_word = 32'h00000000;
            end
        endcase
    end

    // avalon slave: one wait cycle, read data registered
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h00000000;
        end else begin
            avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
            // data is captured while waitrequest is still high, so it stands at the accept edge
            if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
                avs_readdata_o <= read_word;
            end
        end
    end
endmodule

// ### hw/sgt_consts.vh
`ifndef SGT_CONSTS_VH
`define SGT_CONSTS_VH

// register word addresses
`define SGT_ADDR_CTRL 4'h0
`define SGT_ADDR_GATE 4'h1
`define SGT_ADDR_CNT_LO 4'h2
`define SGT_ADDR_CNT_HI 4'h3
`define SGT_ADDR_STAT 4'h4
`define SGT_ADDR_MASK 4'h5
`define SGT_ADDR_W 4

// timer_control_reg fields
`define SGT_CTRL_ON 0
`define SGT_CTRL_SYNC_BYP 2
`define SGT_CTRL_OSC_EN 3
`define SGT_CTRL_PS_LO 4
`define SGT_CTRL_PS_HI 5
`define SGT_CTRL_CS_LO 6
`define SGT_CTRL_CS_HI 7
`define SGT_CTRL_RST 8'h00

// gate_control_reg fields
`define SGT_GATE_POL 6
`define SGT_GATE_QUAL 7
`define SGT_GATE_RST 8'h00

// clock source codes
`define SGT_CS_INSTR 2'h0
`define SGT_CS_SYS 2'h1
`define SGT_CS_PIN 2'h2
`define SGT_CS_CAP 2'h3

// status bit: overflow_flag
`define SGT_STAT_OVF 0

// instruction clock is the system clock divided by this
`define SGT_INSTR_DIV 3'h4
`define SGT_INSTR_DIV_W 2

`endif

// ### hw/sgt_prescale.v
`include "sgt_consts.vh"

// prescaler: emits one tick every 1, 2, 4 or 8 input ticks
module sgt_prescale (
    input wire core_clk_i,
    input wire rst_i,
    input wire clear_i,
    input wire tick_i,
    input wire [1:0] sel_i,
    output reg tick_o
);
    reg [2:0] div_reg;
    wire [2:0] div_next;
    wire [2:0] mask;

    assign mask = (sel_i == 2'h0) ? 3'h0 : (sel_i == 2'h1) ? 3'h1 : (sel_i == 2'h2) ? 3'h3 : 3'h7;
    assign div_next = div_reg + 3'h1;

    always @(posedge core_clk_i) begin
        if (rst_i || clear_i) begin
            div_reg <= 3'h0;
            tick_o <= 1'b0;
        end else begin
            tick_o <= 1'b0;
            if (tick_i) begin
                if ((div_reg & mask) == mask) begin
                    div_reg <= 3'h0;
                    tick_o <= 1'b1;
                end else begin
                    div_reg <= div_next;
                end
            end
        end
    end
endmodule

// ### verif/sgt_timer_asserts.sv
`include "sgt_consts.vh"

module sgt_timer_asserts (
    input wire core_clk_i,
    input wire rst_i,
    input wire [3:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    input wire [31:0] avs_readdata_o,
    input wire avs_waitrequest_o,
    input wire crystal_osc_run_o,
    input wire irq_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    wire req = avs_read_i | avs_write_i;
    wire acc_w = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
    reg mask_shadow_reg;
    // mirror of the mask bit, so read-back can be judged without seeing inside
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            mask_shadow_reg <= 1'b0;
        end else if (acc_w && avs_address_i == `SGT_ADDR_MASK) begin
            mask_shadow_reg <= avs_writedata_i[0];
        end
    end
    req_answer_a: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("request not answered");
    wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    rdata_hold_a: assert property (!req |=> $stable(avs_readdata_o))
        else $error("read data moved while idle");
    unmapped_zero_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i > 4'h5
        |-> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
    osc_follow_a: assert property (acc_w && avs_address_i == `SGT_ADDR_CTRL
        |=> ##2 crystal_osc_run_o == $past(avs_writedata_i[3], 3)) else $error("oscillator run wrong");
    irq_fall_a: assert property ($fell(irq_o) |-> $past(avs_write_i) || $past(avs_write_i, 2))
        else $error("interrupt dropped without write");
    mask_off_a: assert property (acc_w && avs_address_i == `SGT_ADDR_MASK && !avs_writedata_i[0]
        |=> ##1 !irq_o) else $error("masked interrupt still high");
    mask_back_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == `SGT_ADDR_MASK
        |-> avs_readdata_o[0] == mask_shadow_reg) else $error("mask read-back wrong");
endmodule

bind sgt_timer sgt_timer_asserts chk (.core_clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .crystal_osc_run_o, .irq_o);

// ### verif/sgt_timer_bench.sv
`include "sgt_consts.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module sgt_timer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_i = 0, rst_i = 1, rd = 0, wr = 0, gate = 0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [2:0] ext = 3'h0;
    logic [7:0] a, b;
    logic [7:0] gq [4] = '{8'hC0, 8'hC0, 8'h80, 8'h40};
    logic [7:0] gx [4] = '{8'h00, 8'h40, 8'h40, 8'h40};
    logic [7:0] xc [6] = '{8'h81, 8'h89, 8'h89, 8'hC1, 8'h85, 8'hA1};
    logic [7:0] xe [6] = '{8'h04, 8'h00, 8'h04, 8'h04, 8'h04, 8'h01};
    int xl [6] = '{0, 0, 2, 1, 0, 0};
    wire [31:0] rdo;
    wire wait_o, osc_o, irq;
    int n_mismatch = 0, n_compared = 0, cyc = 0;

    always #20 core_clk_i = ~core_clk_i;

    sgt_timer dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF), .avs_readdata_o(rdo),
        .avs_waitrequest_o(wait_o), .external_clock_pin_i(ext[0]), .cap_sense_osc_i(ext[1]),
        .crystal_osc_clk_i(ext[2]), .gate_count_enable_i(gate), .crystal_osc_run_o(osc_o), .irq_o(irq));

    task print_verdict();
        if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // whole run is a few thousand cycles; this only catches a hang
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic acc(input logic w, input logic [3:0] ad, input logic [7:0] d, output logic [31:0] q);
        @(posedge core_clk_i);
        wr <= w;
        rd <= !w;
        addr <= ad;
        wdata <= {24'h0, d};
        do @(posedge core_clk_i); while (wait_o !== 1'b0);
        q = rdo;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic wreg(input logic [3:0] ad, input logic [7:0] d);
        acc(1'b1, ad, d, rdata);
    endtask

    task automatic rreg(input logic [3:0] ad, output logic [7:0] q);
        acc(1'b0, ad, 8'h00, rdata);
        q = rdata[7:0];
    endtask

    // external source idles low between bursts
    task automatic pulse(input int line, input int k);
        repeat (k) begin
            @(posedge core_clk_i) ext[line] <= 1'b1;
            repeat (4) @(posedge core_clk_i);
            ext[line] <= 1'b0;
            repeat (4) @(posedge core_clk_i);
        end
    endtask

    // two low-byte reads exactly 64 cycles apart, so every divide ratio gives a whole number
    task automatic rate(input logic [7:0] ctl, input logic [7:0] exp);
        wreg(`SGT_ADDR_CTRL, ctl);
        rreg(`SGT_ADDR_CNT_LO, a);
        repeat (61) @(posedge core_clk_i);
        rreg(`SGT_ADDR_CNT_LO, b);
        `CHK(b - a, exp)
    endtask

    initial begin
        logic [7:0] v;
        repeat (6) @(posedge core_clk_i);
        rst_i <= 1'b0;
        wreg(4'h6, 8'hFF);
        for (int i = 0; i < 7; i++) begin
            acc(1'b0, i[3:0], 8'h00, rdata);
            `CHK(rdata, 32'h0)
        end
        wreg(`SGT_ADDR_CNT_HI, 8'h12);
        wreg(`SGT_ADDR_CNT_LO, 8'h34);
        rreg(`SGT_ADDR_CNT_HI, v);
        `CHK(v, 8'h12)
        rreg(`SGT_ADDR_CNT_LO, v);
        `CHK(v, 8'h34)
        wreg(`SGT_ADDR_GATE, 8'h80);
        rate(8'h40, 8'h00);
        wreg(`SGT_ADDR_GATE, 8'h00);
        for (int s = 0; s < 2; s++)
            for (int p = 0; p < 4; p++)
                rate({s[1:0], p[1:0], 4'h1}, (s ? 8'h40 : 8'h10) >> p);
        for (int i = 0; i < 4; i++) begin
            wreg(`SGT_ADDR_GATE, gq[i]);
            gate <= (i == 1);
            rate(8'h41, gx[i]);
        end
        for (int i = 0; i < 6; i++) begin
            wreg(`SGT_ADDR_CTRL, xc[i]);
            wreg(`SGT_ADDR_CNT_LO, 8'h00);
            pulse(xl[i], 5);
            rreg(`SGT_ADDR_CNT_LO, v);
            `CHK(v, xe[i])
            if (i == 2) `CHK(osc_o, 1'b1)
        end
        pulse(0, 3);
        wreg(`SGT_ADDR_CNT_LO, 8'h00);
        pulse(0, 2);
        rreg(`SGT_ADDR_CNT_LO, v);
        `CHK(v, 8'h00)
        pulse(0, 3);
        rreg(`SGT_ADDR_CNT_LO, v);
        `CHK(v, 8'h01)
        wreg(`SGT_ADDR_CTRL, 8'h40);
        wreg(`SGT_ADDR_MASK, 8'h01);
        wreg(`SGT_ADDR_CNT_HI, 8'hFC);
        wreg(`SGT_ADDR_CNT_LO, 8'h00);
        wreg(`SGT_ADDR_STAT, 8'h01);
        wreg(`SGT_ADDR_CTRL, 8'h41);
        repeat (1000) @(posedge core_clk_i);
        rreg(`SGT_ADDR_STAT, v);
        `CHK({v[0], irq}, 2'b00)
        repeat (40) @(posedge core_clk_i);
        rreg(`SGT_ADDR_STAT, v);
        `CHK({v[0], irq}, 2'b11)
        wreg(`SGT_ADDR_MASK, 8'h00);
        repeat (2) @(posedge core_clk_i);
        `CHK(irq, 1'b0)
        wreg(`SGT_ADDR_STAT, 8'h01);
        wreg(`SGT_ADDR_MASK, 8'h01);
        rreg(`SGT_ADDR_STAT, v);
        `CHK({v[0], irq}, 2'b00)
        print_verdict();
    end
endmodule
